// file: include/phy_cfg_pkg.sv
// phy_cfg_pkg: constants, states and carriers for the config block
// assumes: 50 MHz core clock; shared by phy_cfg_ctrl and mgmt_serial
package phy_cfg_pkg;
  // timing, in ns as stated, then in core cycles
  localparam int CLK_PERIOD_NS = 20;
  localparam int HW_RST_MIN_NS = 1000; // least low time on reset pin
  localparam int SW_RST_NS     = 1000; // soft reset length
  localparam int MGMT_WAIT_NS  = 3000; // station quiet time after soft reset
  localparam logic [6:0] HW_RST_CYC =
    7'((HW_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] SW_RST_CYC = 7'(SW_RST_NS / CLK_PERIOD_NS);
  localparam logic [6:0] LATCH_CYC  = 7'h08; // strap settle time

  // register map and fields
  localparam logic [4:0] REG_BASIC    = 5'h00; // basic_control_reg
  localparam logic [4:0] REG_PHY_CTRL = 5'h19; // phy_control_reg
  localparam int BC_RESET_BIT  = 15;
  localparam int BC_ISO_BIT    = 10;
  localparam int BC_DUPLEX_BIT = 8;
  localparam int PC_ADDR_POS   = 0;
  localparam logic BC_DUPLEX_RST = 1'b0;
  localparam logic [4:0] PULL_UP_MASK = 5'h01; // address bit 0
  localparam logic [4:0] PULL_DN_MASK = 5'h1E; // address bits 4..1

  // management frame
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] PRE_BITS  = 6'h20;
  localparam logic [5:0] HDR_LAST  = 6'h0C;
  localparam logic [5:0] DATA_LAST = 6'h0F;
  localparam int HDR_START_POS = 12;
  localparam int HDR_OP_POS    = 10;
  localparam int HDR_PHY_POS   = 5;
  localparam int HDR_REG_POS   = 0;
  localparam int DATA_MSB      = 15;

  // synchroniser vector layout
  localparam int SYNC_W  = 13;
  localparam int P_MDC   = 0;
  localparam int P_MDIO  = 1;
  localparam int P_RSTN  = 2;
  localparam int P_STRAP = 3;
  localparam int P_TXD   = 8;
  localparam int P_TXEN  = 12;
  localparam logic [12:0] SYNC_RST = 13'h0004; // reset pin seen high

  typedef enum logic [3:0] {
    ST_LATCH = 4'h1, ST_RUN = 4'h2, ST_HWRST = 4'h4, ST_SWRST = 4'h8
  } rst_st_e;

  typedef enum logic [4:0] {
    MS_PRE = 5'h01, MS_IDLE = 5'h02, MS_HDR = 5'h04,
    MS_TA = 5'h08, MS_DAT = 5'h10
  } mgmt_st_e;

  typedef struct packed {
    logic       tx_clk;
    logic       rx_clk;
    logic       rx_dv;
    logic       rx_er;
    logic [3:0] rxd;
  } core_mii_s;

  typedef struct packed {
    logic       tx_clk;
    logic       rx_clk;
    logic       rx_dv;
    logic       rx_er;
    logic [3:0] rxd;
    logic       col;
    logic       crs;
  } mii_pin_s;
endpackage

// file: design/mgmt_serial.sv
// mgmt_serial: serial management frame slave, 16-bit registers
// assumes: bit_stb marks a filtered clock rise; mdio_in is filtered
module mgmt_serial (
  input  wire logic        clk,       // core clock
  input  wire logic        rst,       // sync reset, high
  input  wire logic        bit_stb,   // management clock rise
  input  wire logic        mdio_in,   // data line level
  input  wire logic [4:0]  phy_addr,  // own station address
  input  wire logic [15:0] rd_data,   // register read value
  output logic      [4:0]  reg_addr,  // addressed register
  output logic             wr_stb,    // write pulse
  output logic      [15:0] wr_data,   // write value
  output logic             mdio_out,  // data line drive value
  output logic             mdio_oe    // data line drive enable
);
  import phy_cfg_pkg::*;

  mgmt_st_e    st_r, st_nxt;       // frame position
  logic [5:0]  cnt_r, cnt_nxt;     // bit count in field
  logic [15:0] sh_r, sh_nxt;       // shift register
  logic        rd_r, rd_nxt;       // frame is a read
  logic        me_r, me_nxt;       // frame is for us
  logic        out_r, out_nxt;     // drive value
  logic        oe_r, oe_nxt;       // drive enable
  logic        stb_r, stb_nxt;     // write strobe
  logic [4:0]  reg_r, reg_nxt;     // register number
  logic [15:0] sh_in;              // shift with new bit
  logic [1:0]  op;                 // opcode as received

  assign sh_in = {sh_r[14:0], mdio_in};
  assign op    = sh_in[HDR_OP_POS +: 2];

  // frame walker; a bad start, opcode or write turnaround demands preamble again
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    sh_nxt  = sh_r;
    rd_nxt  = rd_r;
    me_nxt  = me_r;
    out_nxt = out_r;
    oe_nxt  = oe_r;
    stb_nxt = 1'b0;
    reg_nxt = reg_r;
    if (bit_stb) begin
      sh_nxt = sh_in;
      case (st_r)
        MS_PRE: begin
          if (mdio_in) begin
            cnt_nxt = (cnt_r == PRE_BITS) ? cnt_r : cnt_r + 6'h01;
          end else if (cnt_r == PRE_BITS) begin
            st_nxt  = MS_HDR;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = '0;
          end
        end
        MS_IDLE: if (!mdio_in) begin // no preamble needed once in sync
          st_nxt  = MS_HDR;
          cnt_nxt = '0;
        end
        MS_HDR: begin
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == HDR_LAST) begin
            cnt_nxt = '0;
            rd_nxt  = (op == OP_READ);
            me_nxt  = (sh_in[HDR_PHY_POS +: 5] == phy_addr);
            reg_nxt = sh_in[HDR_REG_POS +: 5];
            st_nxt  = (sh_in[HDR_START_POS] && (op == OP_READ || op == OP_WRITE))
                      ? MS_TA : MS_PRE;
          end
        end
        MS_TA: begin
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == '0) begin
            oe_nxt  = rd_r & me_r; // second turnaround bit driven low
            out_nxt = 1'b0;
            if (!rd_r && !mdio_in) st_nxt = MS_PRE;
          end else begin
            st_nxt  = MS_DAT;
            cnt_nxt = '0;
            if (rd_r) begin
              sh_nxt  = rd_data << 1;
              out_nxt = rd_data[DATA_MSB];
            end else if (mdio_in) begin
              st_nxt = MS_PRE;
            end
          end
        end
        MS_DAT: begin
          cnt_nxt = cnt_r + 6'h01;
          if (rd_r) begin
            sh_nxt  = sh_r << 1;
            out_nxt = sh_r[DATA_MSB];
          end
          if (cnt_r == DATA_LAST) begin
            st_nxt  = MS_IDLE;
            oe_nxt  = 1'b0;
            stb_nxt = me_r & ~rd_r;
          end
        end
        default: st_nxt = MS_PRE;
      endcase
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r  <= MS_PRE;
      cnt_r <= '0;
      sh_r  <= '0;
      rd_r  <= 1'b0;
      me_r  <= 1'b0;
      out_r <= 1'b0;
      oe_r  <= 1'b0;
      stb_r <= 1'b0;
      reg_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r  <= sh_nxt;
      rd_r  <= rd_nxt;
      me_r  <= me_nxt;
      out_r <= out_nxt;
      oe_r  <= oe_nxt;
      stb_r <= stb_nxt;
      reg_r <= reg_nxt;
    end
  end

  assign reg_addr = reg_r;
  assign wr_stb   = stb_r;
  assign wr_data  = sh_r;
  assign mdio_out = out_r;
  assign mdio_oe  = oe_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_ta_drive_low:
    assert property ((bit_stb && st_r == MS_TA && cnt_r == '0 && rd_r && me_r)
                     |=> (oe_r && !out_r)) else $error("turnaround not driven low");
  chk_foreign_quiet:
    assert property (!me_r |-> !oe_r) else $error("drove line for foreign frame");
  chk_write_end:
    assert property (stb_r |-> ($past(st_r) == MS_DAT && st_r == MS_IDLE))
      else $error("write strobe outside frame end");
endmodule

// file: design/phy_cfg_ctrl.sv
// phy_cfg_ctrl: station address straps, isolate, duplex view, resets
// assumes: pins resolved outside from the enables; core mii same clock
//
// Notes on behaviour
// - latch five strap bits into address field
// - straps on COL and RXD, pins then resume
// - strap zero isolates; written zero does not
// - pulls give default address 00001
// - basic control bit 10 selects isolate
// - isolate ignores transmit, floats MII outputs
// - management keeps answering while isolated
// - isolated transmitter sends no packet data
// - negotiation and link keep running isolated
// - half duplex carrier covers transmit and receive
// - full duplex: no collision, carrier receive only
// - other MII signals same in both duplexes
// - parallel detection settles on half duplex
// - power-on reset needs no external reset
// - reset pin low 1 us resets, relatches
// - bit 15 soft reset, about 1 us
// - 16-bit registers over serial management
module phy_cfg_ctrl (
  input  wire logic                   CORE_CLK,       // 50 MHz core clock
  input  wire logic                   RST,            // power-on reset, sync high
  input  wire logic                   RESET_N_PIN,    // hardware reset pin, low
  input  wire logic                   MDC,            // management clock pin
  input  wire logic                   MDIO_I,         // management data in
  output logic                        MDIO_O,         // management data out
  output logic                        MDIO_OE,        // management drive enable
  input  wire logic [4:0]             STRAP_I,        // COL, RXD3..0 pin levels
  output logic      [4:0]             STRAP_PULL_UP,  // weak pull-up per strap
  output logic      [4:0]             STRAP_PULL_DN,  // weak pull-down per strap
  input  wire logic [3:0]             MII_TXD,        // transmit data pins
  input  wire logic                   MII_TX_EN,      // transmit enable pin
  input  wire phy_cfg_pkg::core_mii_s CORE_MII,       // core mii signals
  input  wire logic                   TX_ACT,         // transmit activity
  input  wire logic                   RX_ACT,         // receive activity
  input  wire logic                   LINK_BY_AN,     // link by negotiation
  input  wire logic                   AN_FULL_DUPLEX, // negotiated full duplex
  input  wire logic                   LINK_BY_PD,     // link by parallel detect
  output phy_cfg_pkg::mii_pin_s       MII_O,          // mii output values
  output phy_cfg_pkg::mii_pin_s       MII_OE,         // mii output enables
  output logic      [3:0]             PCS_TXD,        // data to transmitter
  output logic                        PCS_TX_EN,      // packet to transmitter
  output logic                        FULL_DUPLEX,    // resolved duplex
  output logic                        AN_RUN,         // negotiation enable
  output logic                        ISOLATE,        // isolate mode
  output logic                        DEV_RST         // reset to rest of device
);
  import phy_cfg_pkg::*;

  // pin synchroniser, three stages
  logic [SYNC_W-1:0] pin_vec;             // raw pins
  logic [SYNC_W-1:0] s1_r, s2_r, s3_r;    // stages
  logic [SYNC_W-1:0] filt_r, filt_nxt;    // agreed value
  logic              mdc_d_r, mdc_d_nxt;  // last clock level
  logic              mdc_rise;            // clock rise seen
  logic              pin_low;             // reset pin held low
  logic [4:0]        strap;               // strap levels

  // reset sequencer and registers
  rst_st_e     st_r, st_nxt;         // reset state
  logic [6:0]  cnt_r, cnt_nxt;       // state timer
  logic [6:0]  hwcnt_r, hwcnt_nxt;   // reset pin low time
  logic        hw_trig;              // pin low long enough
  logic [4:0]  addr_r, addr_nxt;     // station address
  logic        iso_r, iso_nxt;       // isolate bit
  logic        dup_r, dup_nxt;       // duplex bit
  logic        run;                  // normal operation
  logic        mgmt_rst;             // management reset

  // management link
  logic [4:0]  reg_addr;   // addressed register
  logic        wr_stb;     // write pulse
  logic [15:0] wr_data;    // write value
  logic [15:0] rd_data;    // read value
  logic        bc_wr;      // basic control write
  logic        pc_wr;      // phy control write

  // outputs
  mii_pin_s    mo_r, mo_nxt;         // mii values
  mii_pin_s    moe_r, moe_nxt;       // mii enables
  logic [3:0]  ptxd_r, ptxd_nxt;     // transmit data
  logic        pen_r, pen_nxt;       // transmit enable
  logic        fd_r, fd_nxt;         // duplex out
  logic        an_r, an_nxt;         // negotiation enable
  logic        drst_r, drst_nxt;     // device reset out
  logic [4:0]  pu_r, pu_nxt;         // pull-ups
  logic [4:0]  pd_r, pd_nxt;         // pull-downs
  logic        fd;                   // duplex now

  assign pin_vec  = {MII_TX_EN, MII_TXD, STRAP_I, RESET_N_PIN, MDIO_I, MDC};
  assign mdc_rise = filt_r[P_MDC] & ~mdc_d_r;
  assign pin_low  = ~filt_r[P_RSTN];
  assign strap    = filt_r[P_STRAP +: 5];
  assign hw_trig  = (hwcnt_r == HW_RST_CYC);
  assign run      = (st_r == ST_RUN);
  assign mgmt_rst = RST | ~run;
  assign bc_wr    = wr_stb & run & (reg_addr == REG_BASIC);
  assign pc_wr    = wr_stb & run & (reg_addr == REG_PHY_CTRL);

  // a bit changes once stages two and three agree; stage one feeds only two
  always_comb begin
    filt_nxt  = (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
    mdc_d_nxt = filt_r[P_MDC];
  end

  // synchroniser registers
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s1_r    <= SYNC_RST;
      s2_r    <= SYNC_RST;
      s3_r    <= SYNC_RST;
      filt_r  <= SYNC_RST;
      mdc_d_r <= 1'b0;
    end else begin
      s1_r    <= pin_vec;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      filt_r  <= filt_nxt;
      mdc_d_r <= mdc_d_nxt;
    end
  end

  // reset sequencing and register writes
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    addr_nxt = addr_r;
    iso_nxt  = iso_r;
    dup_nxt  = dup_r;
    // pin low time saturates at the trigger count
    hwcnt_nxt = pin_low ? (hw_trig ? hwcnt_r : hwcnt_r + 7'h01) : '0;
    case (st_r)
      ST_LATCH: begin
        cnt_nxt = cnt_r + 7'h01;
        if (cnt_r == LATCH_CYC) begin
          addr_nxt = strap;
          iso_nxt  = (strap == '0);
          st_nxt   = ST_RUN;
        end
      end
      ST_RUN: begin
        if (bc_wr) begin
          iso_nxt = wr_data[BC_ISO_BIT];
          dup_nxt = wr_data[BC_DUPLEX_BIT];
          if (wr_data[BC_RESET_BIT]) begin
            st_nxt  = ST_SWRST;
            cnt_nxt = '0;
          end
        end
        // writing zero here never touches isolate
        if (pc_wr) addr_nxt = wr_data[PC_ADDR_POS +: 5];
      end
      ST_SWRST: begin
        cnt_nxt = cnt_r + 7'h01;
        iso_nxt = 1'b0;
        dup_nxt = BC_DUPLEX_RST;
        if (cnt_r == SW_RST_CYC - 7'h01) begin
          st_nxt  = ST_LATCH;
          cnt_nxt = '0;
        end
      end
      ST_HWRST: begin
        iso_nxt = 1'b0;
        dup_nxt = BC_DUPLEX_RST;
        if (!pin_low) begin
          st_nxt  = ST_LATCH;
          cnt_nxt = '0;
        end
      end
      default: st_nxt = ST_LATCH;
    endcase
    // the pin overrides any state, a soft reset included
    if (hw_trig && st_r != ST_HWRST) begin
      st_nxt  = ST_HWRST;
      cnt_nxt = '0;
      iso_nxt = 1'b0;
      dup_nxt = BC_DUPLEX_RST;
    end
  end

  // sequencer registers; power-up goes straight to strap latching
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_r    <= ST_LATCH;
      cnt_r   <= '0;
      hwcnt_r <= '0;
      addr_r  <= '0;
      iso_r   <= 1'b0;
      dup_r   <= BC_DUPLEX_RST;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      hwcnt_r <= hwcnt_nxt;
      addr_r  <= addr_nxt;
      iso_r   <= iso_nxt;
      dup_r   <= dup_nxt;
    end
  end

  // register read view; reserved bits read zero
  always_comb begin
    rd_data = '0;
    case (reg_addr)
      REG_BASIC: begin
        rd_data[BC_RESET_BIT]  = (st_r == ST_SWRST);
        rd_data[BC_ISO_BIT]    = iso_r;
        rd_data[BC_DUPLEX_BIT] = dup_r;
      end
      REG_PHY_CTRL: rd_data[PC_ADDR_POS +: 5] = addr_r;
      default: rd_data = '0;
    endcase
  end

  // management slave; held in reset outside normal operation
  mgmt_serial u_mgmt (
    .clk      (CORE_CLK),
    .rst      (mgmt_rst),
    .bit_stb  (mdc_rise),
    .mdio_in  (filt_r[P_MDIO]),
    .phy_addr (addr_r),
    .rd_data  (rd_data),
    .reg_addr (reg_addr),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .mdio_out (MDIO_O),
    .mdio_oe  (MDIO_OE)
  );

  // mii view, duplex resolution and transmit gating
  always_comb begin
    // parallel detection cannot learn duplex, so half wins
    fd = LINK_BY_PD ? 1'b0 : (LINK_BY_AN ? AN_FULL_DUPLEX : dup_r);
    mo_nxt.tx_clk = CORE_MII.tx_clk;
    mo_nxt.rx_clk = CORE_MII.rx_clk;
    mo_nxt.rx_dv  = CORE_MII.rx_dv;
    mo_nxt.rx_er  = CORE_MII.rx_er;
    mo_nxt.rxd    = CORE_MII.rxd;
    mo_nxt.col    = ~fd & TX_ACT & RX_ACT;
    mo_nxt.crs    = fd ? RX_ACT : (TX_ACT | RX_ACT);
    // strap pins float in reset so straps can be read
    moe_nxt  = (run && !iso_r) ? '1 : '0;
    pen_nxt  = run & ~iso_r & filt_r[P_TXEN];
    ptxd_nxt = pen_nxt ? filt_r[P_TXD +: 4] : '0;
    fd_nxt   = fd;
    an_nxt   = run;
    drst_nxt = ~run;
    pu_nxt   = PULL_UP_MASK;
    pd_nxt   = PULL_DN_MASK;
  end

  // output registers
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mo_r   <= '0;
      moe_r  <= '0;
      ptxd_r <= '0;
      pen_r  <= 1'b0;
      fd_r   <= 1'b0;
      an_r   <= 1'b0;
      drst_r <= 1'b1;
      pu_r   <= PULL_UP_MASK;
      pd_r   <= PULL_DN_MASK;
    end else begin
      mo_r   <= mo_nxt;
      moe_r  <= moe_nxt;
      ptxd_r <= ptxd_nxt;
      pen_r  <= pen_nxt;
      fd_r   <= fd_nxt;
      an_r   <= an_nxt;
      drst_r <= drst_nxt;
      pu_r   <= pu_nxt;
      pd_r   <= pd_nxt;
    end
  end

  assign MII_O         = mo_r;
  assign MII_OE        = moe_r;
  assign PCS_TXD       = ptxd_r;
  assign PCS_TX_EN     = pen_r;
  assign FULL_DUPLEX   = fd_r;
  assign AN_RUN        = an_r;
  assign ISOLATE       = iso_r;
  assign DEV_RST       = drst_r;
  assign STRAP_PULL_UP = pu_r;
  assign STRAP_PULL_DN = pd_r;

  localparam int SWR_N = int'(SW_RST_CYC);

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  chk_strap_zero_iso:
    assert property ((st_r == ST_LATCH && cnt_r == LATCH_CYC && strap == '0 && !hw_trig)
                     |=> (iso_r && addr_r == '0)) else $error("zero strap did not isolate");
  chk_addr_write_iso:
    assert property ((pc_wr && !bc_wr && !hw_trig) |=> (iso_r == $past(iso_r)))
      else $error("address write changed isolate");
  chk_iso_float:
    assert property (iso_r |=> (MII_OE == '0)) else $error("mii driven while isolated");
  chk_iso_no_tx:
    assert property (iso_r |=> !PCS_TX_EN) else $error("packet data sent while isolated");
  chk_fd_no_col:
    assert property ((fd && TX_ACT) |=> (!MII_O.col && MII_O.crs == $past(RX_ACT)))
      else $error("full duplex collision or transmit carrier");
  chk_hd_crs:
    assert property ((!fd && (TX_ACT || RX_ACT)) |=> MII_O.crs)
      else $error("half duplex carrier missing");
  chk_pd_half:
    assert property (LINK_BY_PD |=> !FULL_DUPLEX) else $error("parallel detect went full");
  chk_hw_trig:
    assert property ((pin_low && hwcnt_r == HW_RST_CYC - 7'h01) |-> ##2 (st_r == ST_HWRST))
      else $error("long reset pin low not obeyed");
  chk_sw_len:
    assert property (($rose(st_r == ST_SWRST) && !pin_low) |-> ##SWR_N (st_r == ST_LATCH))
      else $error("soft reset length wrong");
  chk_sw_clear:
    assert property ((st_r == ST_SWRST) ##1 (st_r == ST_LATCH) |-> !rd_data[BC_RESET_BIT])
      else $error("soft reset bit not cleared");
  chk_strap_float:
    assert property ((st_r != ST_RUN) |=> (MII_OE.rxd == '0 && !MII_OE.col))
      else $error("strap pins driven in reset");
endmodule

// file: tb/mgmt_station.sv
// mgmt_station: behavioural management station on MDC and MDIO
// assumes: MDIO pulled up by the bench; core clock paces the phases
module mgmt_station import phy_cfg_pkg::*; (
  input  wire logic clk,    // core clock
  input  wire logic mdio,   // resolved data line
  output logic      mdc,    // management clock
  output logic      sta_o,  // drive value
  output logic      sta_oe  // drive enable
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle: clock low, line released
  initial begin
    mdc = 1'b0;
    sta_o = 1'b1;
    sta_oe = 1'b0;
  end

  // one bit: six cycles each phase, so the pin filter sees every edge
  task automatic bit_io(input logic drv, input logic v, output logic smp);
    sta_oe <= drv;
    sta_o  <= v;
    repeat (6) @(posedge clk);
    smp = mdio; // pre-edge value, settled since the last rise
    mdc <= 1'b1;
    repeat (6) @(posedge clk);
    mdc <= 1'b0;
  endtask

  // released line floats high through the pull-up
  task automatic preamble();
    logic s;
    repeat (32) bit_io(1'b0, 1'b0, s);
  endtask

  // whole frame: header, turnaround, 16 data bits MSB first, one idle bit
  task automatic frame(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [15:0] hdr;
    logic        s;
    hdr = {2'b01, wr ? OP_WRITE : OP_READ, pa, ra, wr ? 2'b10 : 2'b11};
    for (int i = 15; i >= 0; i--) bit_io(wr || i > 1, hdr[i], s);
    for (int i = 15; i >= 0; i--) begin
      bit_io(wr, wd[i], s);
      rd[i] = s;
    end
    bit_io(1'b0, 1'b1, s);
  endtask
endmodule

// file: tb/tb_phy_address_isolate_reset_ctrl.sv
// tb: scenario tasks for straps, isolate, duplex view and resets
// assumes: bench resolves MDIO pull-up and strap pulls from the enables
module tb_phy_address_isolate_reset_ctrl import phy_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, rst_n = 1'b1, tx_en = 1'b0, tx_act = 1'b0;
  logic rx_act = 1'b0, link_an = 1'b0, an_fd = 1'b0, link_pd = 1'b0, strap_en = 1'b0;
  logic [4:0] strap_val = 5'h00;   // strap drive value
  logic [3:0] txd       = 4'h0;    // mac transmit nibble
  core_mii_s  core      = '0;      // core mii values
  wire logic  mdc, sta_o, sta_oe, mdio_o, mdio_oe, mdio;
  wire logic [4:0] pull_up, pull_dn, strap_pin;
  mii_pin_s   mii_o, mii_oe;       // mii values and enables
  logic [3:0] pcs_txd;             // gated transmit nibble
  logic       pcs_tx_en, fd, an_run, iso, dev_rst;
  logic [15:0] rd;                 // last read word
  int         fail_count = 0, n_checks = 0;

  always #10 clk = ~clk;
  // pull-up wins only when nobody drives
  assign mdio = mdio_oe ? mdio_o : (sta_oe ? sta_o : 1'b1);
  assign strap_pin = strap_en ? strap_val : (pull_up & ~pull_dn);

  phy_cfg_ctrl phy_cfg_ctrl_inst (.CORE_CLK(clk), .RST(rst), .RESET_N_PIN(rst_n),
    .MDC(mdc), .MDIO_I(mdio), .MDIO_O(mdio_o), .MDIO_OE(mdio_oe), .STRAP_I(strap_pin),
    .STRAP_PULL_UP(pull_up), .STRAP_PULL_DN(pull_dn), .MII_TXD(txd), .MII_TX_EN(tx_en),
    .CORE_MII(core), .TX_ACT(tx_act), .RX_ACT(rx_act), .LINK_BY_AN(link_an),
    .AN_FULL_DUPLEX(an_fd), .LINK_BY_PD(link_pd), .MII_O(mii_o), .MII_OE(mii_oe),
    .PCS_TXD(pcs_txd), .PCS_TX_EN(pcs_tx_en), .FULL_DUPLEX(fd), .AN_RUN(an_run),
    .ISOLATE(iso), .DEV_RST(dev_rst));
  mgmt_station mgmt_station_inst (.clk(clk), .mdio(mdio), .mdc(mdc), .sta_o(sta_o),
    .sta_oe(sta_oe));

  task automatic check_bit(string n, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %0b seen %0b", n, e, g);
    end
  endtask
  task automatic check_word(string n, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_reg(input logic [4:0] pa, input logic [4:0] ra);
    mgmt_station_inst.frame(1'b0, pa, ra, 16'h0000, rd);
  endtask
  task automatic wr_reg(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
    mgmt_station_inst.frame(1'b1, pa, ra, d, rd);
  endtask
  // 60 cycles low is 1.2 us, above the pin filter minimum
  task automatic hw_reset(input logic [4:0] s);
    strap_val <= s;
    strap_en <= 1'b1;
    rst_n <= 1'b0;
    repeat (60) @(posedge clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
    mgmt_station_inst.preamble();
  endtask
  task automatic t_default();
    mgmt_station_inst.preamble();
    rd_reg(5'h01, REG_PHY_CTRL);
    check_word("phy_control", 16'h0001, rd);
    check_bit("isolate", 1'b0, iso);
  endtask
  // levels change at an edge; outputs looked at three edges later
  task automatic t_duplex();
    {link_an, an_fd, tx_act, rx_act, core.rx_dv} <= 5'b11101;
    repeat (3) @(posedge clk);
    check_bit("crs fd", 1'b0, mii_o.crs);
    check_bit("rx_dv fd", 1'b1, mii_o.rx_dv);
    rx_act <= 1'b1;
    repeat (3) @(posedge clk);
    check_bit("col fd", 1'b0, mii_o.col);
    {an_fd, rx_act} <= 2'b00;
    repeat (3) @(posedge clk);
    check_bit("crs hd", 1'b1, mii_o.crs);
    rx_act <= 1'b1;
    repeat (3) @(posedge clk);
    check_bit("col hd", 1'b1, mii_o.col);
    {link_pd, an_fd} <= 2'b11;
    core.rxd <= 4'hA;
    repeat (3) @(posedge clk);
    check_bit("duplex pd", 1'b0, fd);
    check_bit("rx_dv hd", 1'b1, mii_o.rx_dv);
    check_word("mii values hd", 16'h00AB, 16'(mii_o));
    {link_an, an_fd, link_pd, tx_act, rx_act} <= 5'h00;
    core <= '0;
  endtask
  task automatic t_strap();
    hw_reset(5'h16);
    rd_reg(5'h16, REG_PHY_CTRL);
    check_word("strapped address", 16'h0016, rd);
    check_word("mii enables", 16'h03FF, 16'(mii_oe));
    {tx_en, txd} <= 5'h15;
    repeat (10) @(posedge clk);
    check_bit("tx passes", 1'b1, pcs_tx_en);
    check_word("txd passes", 16'h0005, 16'(pcs_txd));
    {tx_en, txd} <= 5'h00;
  endtask
  task automatic t_soft();
    wr_reg(5'h16, REG_PHY_CTRL, 16'h0009);
    rd_reg(5'h09, REG_PHY_CTRL);
    check_word("written address", 16'h0009, rd);
    wr_reg(5'h09, REG_BASIC, 16'h8000);
    check_bit("soft reset active", 1'b1, dev_rst);
    repeat (150) @(posedge clk);
    mgmt_station_inst.preamble();
    rd_reg(5'h16, REG_BASIC);
    check_word("basic after reset", 16'h0000, rd);
    rd_reg(5'h16, REG_PHY_CTRL);
    check_word("relatched address", 16'h0016, rd);
  endtask
  task automatic t_isolate();
    wr_reg(5'h16, REG_PHY_CTRL, 16'h0000);
    check_bit("written zero", 1'b0, iso);
    wr_reg(5'h00, REG_BASIC, 16'h0400);
    {tx_en, txd} <= 5'h15;
    repeat (10) @(posedge clk);
    check_bit("isolate bit", 1'b1, iso);
    check_word("isolated enables", 16'h0000, 16'(mii_oe));
    check_bit("tx gated", 1'b0, pcs_tx_en);
    check_word("txd gated", 16'h0000, 16'(pcs_txd));
    check_bit("an running", 1'b1, an_run);
    rd_reg(5'h00, REG_BASIC);
    check_word("basic isolated", 16'h0400, rd);
    {tx_en, txd} <= 5'h00;
  endtask
  task automatic t_strap_zero();
    hw_reset(5'h00);
    check_bit("strap zero", 1'b1, iso);
    rd_reg(5'h00, REG_PHY_CTRL);
    check_word("zero address", 16'h0000, rd);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog: whole run needs roughly 6300 cycles
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (15) @(posedge clk);
    t_default();
    t_duplex();
    t_strap();
    t_soft();
    t_isolate();
    t_strap_zero();
    report_and_stop();
  end
endmodule
